// ---- core/mcl_modem_ctrl.sv ----
/*
  Modem-control lines of the serial port: RTS/DTR inputs for flow control
  and power-save wake, DSR/DCD/RI outputs from mode and call status.
  Assumes all inputs are synchronous to i_clk_sys and that status and
  event inputs come from the module's protocol controller.
*/
// Operation
// - RTS treated OFF at init, pulled up
// - Flow control: RTS OFF pauses transmission
// - Transmission stops within two characters
// - Setting 2: RTS edge wakes, ON stays (code wakes on RTS only while i_hw_flow_en is low)
// - Default DSR mode: ON only in data
// - Alternate DSR mode: DSR always ON
// - DTR treated OFF at init, pulled up
// - Setting 3: DTR edge wakes, ON stays
// - Default DCD follows carrier and voice calls
// - Packet dial: DCD before connect confirmation
// - Circuit call: DCD before connect string
// - Input prompt commands hold DCD ON
// - Online command mode keeps DCD ON
// - DCD ON until every cause ends
// - Alternate DCD mode: DCD always ON
// - Incoming call rings 1 s on, 4 s off
// - Message arrival gives 1 s pulse
// - Close events retrigger without gap
// - Answer ends call pulse early
// - Extended notification events give 1 s pulse
// - Setting codes: 0 off, 1 cyclic, 2 RTS, 3 DTR
// - No flow control under setting 2
module mcl_modem_ctrl #(
  parameter int WAKE_CYC     = mcl_pkg::WAKE_CYC,
  parameter int RING_ON_CYC  = mcl_pkg::RING_ON_CYC,
  parameter int RING_OFF_CYC = mcl_pkg::RING_OFF_CYC
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rstn,
  // Host-driven lines; 1 = OFF, pull-up already resolved at the pad
  input  wire logic       i_rts_n,
  input  wire logic       i_dtr_n,
  // Configuration
  input  wire logic [1:0] i_power_save_setting,
  input  wire logic       i_hw_flow_en,
  input  wire logic       i_dsr_follow_mode,
  input  wire logic       i_dcd_follow_mode,
  input  wire logic       i_msg_ring_en,
  input  wire logic       i_extended_ring_notification,
  // Status from the protocol controller
  input  wire logic       i_data_mode,
  input  wire logic       i_carrier,
  input  wire logic       i_voice_call,
  input  wire logic       i_data_call,
  input  wire logic       i_input_prompt,
  input  wire logic       i_call_ringing,
  // Single-cycle events
  input  wire logic       i_call_answer,
  input  wire logic       i_msg_arrival,
  input  wire logic       i_ext_event,
  input  wire logic       i_connect_req,
  input  wire logic       i_tx_char_done,
  // Outputs
  output logic            o_dsr_n,
  output logic            o_dcd_n,
  output logic            o_ri_n,
  output logic            o_tx_enable,
  output logic            o_uart_enable,
  output logic            o_wake_done,
  output logic            o_stay_active,
  output logic            o_connect_go,
  output logic            o_flow_eff
);
  localparam int WW = 21;

  initial begin
    if (WAKE_CYC < 1 || WAKE_CYC >= (1 << WW))
      $error("mcl_modem_ctrl: wake count out of range");
  end

  typedef enum logic [1:0] {
    MCL_ST_SLEEP = 2'b00,
    MCL_ST_WAKE  = 2'b01,
    MCL_ST_AWAKE = 2'b10
  } mcl_wake_e;

  typedef struct packed {
    logic          rts_prev;
    logic          dtr_prev;
    mcl_wake_e     wst;
    logic [WW-1:0] wcnt;
    logic [1:0]    stop_cnt;
    logic          tx_en;
    logic          uart_en;
    logic          wake_done;
    logic          stay;
    logic          dsr_n;
    logic          dcd_n;
    logic          conn_go;
    logic          conn_pend;
    logic          flow;
  } mcl_state_s;

  mcl_state_s s_q;
  mcl_state_s s_d;
  logic       ri_on;

  logic       flow_eff;
  logic       ctl_line_n;
  logic       ctl_prev_n;
  logic       ps_line_mode;
  logic       dcd_req;

  // Flow control is forced off under the RTS-controlled setting
  assign flow_eff = i_hw_flow_en &&
                    (i_power_save_setting != mcl_pkg::PSV_RTS_CTRL);
  assign ps_line_mode = (i_power_save_setting == mcl_pkg::PSV_RTS_CTRL && !i_hw_flow_en) ||
                        (i_power_save_setting == mcl_pkg::PSV_DTR_CTRL);
  // Wake line selection: RTS in setting 2, DTR in setting 3
  assign ctl_line_n = (i_power_save_setting == mcl_pkg::PSV_DTR_CTRL) ? i_dtr_n : i_rts_n;
  assign ctl_prev_n = (i_power_save_setting == mcl_pkg::PSV_DTR_CTRL) ? s_q.dtr_prev
                                                                      : s_q.rts_prev;
  // Every cause that asks for DCD ON, ORed so none can drop it early
  assign dcd_req = i_carrier || i_voice_call || i_data_mode ||
                   i_data_call || i_input_prompt;

  always_comb begin
    s_d = s_q;
    s_d.rts_prev = i_rts_n;
    s_d.dtr_prev = i_dtr_n;
    s_d.flow     = flow_eff;

    // Transmit gating: up to two characters may still leave after RTS OFF
    if (!flow_eff || i_rts_n == mcl_pkg::LINE_ON) begin
      s_d.stop_cnt = '0;
      s_d.tx_en    = 1'b1;
    end else begin
      // Counts cycles since RTS went OFF so an idle line pauses too
      if (s_q.stop_cnt != 2'(mcl_pkg::CHAR_STOP_MAX)) begin
        s_d.stop_cnt = s_q.stop_cnt + 2'h1;
      end
      // Pause at the next character boundary or a cycle later, well inside two
      s_d.tx_en = !(i_tx_char_done ||
                    s_q.stop_cnt >= 2'(mcl_pkg::CHAR_STOP_MAX - 1) ||
                    !s_q.tx_en);
    end

    // Power-save wake sequencer
    if (!ps_line_mode) begin
      s_d.wst       = MCL_ST_AWAKE;
      s_d.wcnt      = '0;
      s_d.uart_en   = (i_power_save_setting != mcl_pkg::PSV_CYCLIC);
      s_d.wake_done = 1'b1;
      s_d.stay      = (i_power_save_setting == mcl_pkg::PSV_DISABLED);
    end else begin
      case (s_q.wst)
        MCL_ST_SLEEP: begin
          s_d.uart_en   = 1'b0;
          s_d.wake_done = 1'b0;
          s_d.stay      = 1'b0;
          if (ctl_prev_n == mcl_pkg::LINE_OFF && ctl_line_n == mcl_pkg::LINE_ON) begin
            s_d.wst     = MCL_ST_WAKE;
            s_d.wcnt    = WW'(WAKE_CYC - 1);
            s_d.uart_en = 1'b1;
            s_d.stay    = 1'b1;
          end
        end
        MCL_ST_WAKE: begin
          if (ctl_line_n == mcl_pkg::LINE_OFF) begin
            s_d.wst     = MCL_ST_SLEEP;
            s_d.uart_en = 1'b0;
            s_d.stay    = 1'b0;
          end else if (s_q.wcnt == '0) begin
            s_d.wst       = MCL_ST_AWAKE;
            s_d.wake_done = 1'b1;
          end else begin
            s_d.wcnt = s_q.wcnt - 1'b1;
          end
        end
        MCL_ST_AWAKE: begin
          // Line OFF releases the port; idle is then up to the power manager
          if (ctl_line_n == mcl_pkg::LINE_OFF) begin
            s_d.wst       = MCL_ST_SLEEP;
            s_d.uart_en   = 1'b0;
            s_d.wake_done = 1'b0;
            s_d.stay      = 1'b0;
          end else begin
            s_d.uart_en   = 1'b1;
            s_d.wake_done = 1'b1;
            s_d.stay      = 1'b1;
          end
        end
        default: begin
          s_d.wst = MCL_ST_SLEEP;
        end
      endcase
    end

    // DSR follows data mode, or stays ON in the alternate mode
    s_d.dsr_n = i_dsr_follow_mode ? (i_data_mode ? mcl_pkg::LINE_ON : mcl_pkg::LINE_OFF)
                                  : mcl_pkg::LINE_ON;
    s_d.dcd_n = (!i_dcd_follow_mode || dcd_req) ? mcl_pkg::LINE_ON
                                                : mcl_pkg::LINE_OFF;

    // Connect confirmation waits until DCD is already driven ON
    s_d.conn_go = 1'b0;
    if (i_connect_req) begin
      s_d.conn_pend = 1'b1;
    end
    if (s_q.conn_pend && s_q.dcd_n == mcl_pkg::LINE_ON) begin
      s_d.conn_go   = 1'b1;
      s_d.conn_pend = 1'b0;
    end
  end

  // Reset state: every line OFF except the ON-by-default alternates follow next cycle
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q          <= '0;
      s_q.rts_prev <= mcl_pkg::LINE_OFF;
      s_q.dtr_prev <= mcl_pkg::LINE_OFF;
      s_q.wst      <= MCL_ST_SLEEP;
      s_q.dsr_n    <= mcl_pkg::LINE_OFF;
      s_q.dcd_n    <= mcl_pkg::LINE_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  mcl_ring_timer #(
    .ON_CYC  (RING_ON_CYC),
    .OFF_CYC (RING_OFF_CYC)
  ) u_ring (
    .i_clk_sys     (i_clk_sys),
    .i_rstn        (i_rstn),
    .i_call_ring   (i_call_ringing),
    .i_call_answer (i_call_answer),
    .i_evt         ((i_msg_arrival && i_msg_ring_en) ||
                    (i_ext_event && i_extended_ring_notification)),
    .o_ri_on       (ri_on)
  );

  assign o_dsr_n       = s_q.dsr_n;
  assign o_dcd_n       = s_q.dcd_n;
  assign o_ri_n        = !ri_on;
  assign o_tx_enable   = s_q.tx_en;
  assign o_uart_enable = s_q.uart_en;
  assign o_wake_done   = s_q.wake_done;
  assign o_stay_active = s_q.stay;
  assign o_connect_go  = s_q.conn_go;
  assign o_flow_eff    = s_q.flow;

  a_flow_pause: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (flow_eff && i_rts_n && !i_tx_char_done)[*3] |=> !o_tx_enable)
    else $error("transmit not paused after RTS off");
  a_flow_resume: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (!i_rts_n) |=> o_tx_enable) else $error("transmit not resumed");
  a_no_flow_ps2: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_power_save_setting == mcl_pkg::PSV_RTS_CTRL) |=> !o_flow_eff)
    else $error("flow control active in setting 2");
  a_wake_delay: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (ps_line_mode && s_q.wst == MCL_ST_SLEEP && ctl_prev_n && !ctl_line_n)
    |=> (o_uart_enable && !o_wake_done)) else $error("wake start wrong");
  a_sleep_off: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (ps_line_mode && ctl_line_n && $past(ps_line_mode)) |=> !o_uart_enable)
    else $error("port enabled with control line off");
  a_dsr_data: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_dsr_follow_mode |=> (o_dsr_n == !$past(i_data_mode)))
    else $error("DSR does not follow data mode");
  a_dsr_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !i_dsr_follow_mode |=> !o_dsr_n) else $error("DSR not held on");
  a_dcd_fixed: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !i_dcd_follow_mode |=> !o_dcd_n) else $error("DCD not held on");
  a_dcd_prompt: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_input_prompt || i_data_call) |=> !o_dcd_n)
    else $error("DCD off while a cause holds it");
  a_connect_after: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_connect_go |-> ($past(s_q.dcd_n) == mcl_pkg::LINE_ON))
    else $error("connect before DCD on");
endmodule : mcl_modem_ctrl

// ---- core/mcl_pkg.sv ----
/*
  Shared constants for the modem-control line block: line levels, mode
  codes, power-save setting encodings and time figures.
  Assumes a single 50 MHz module clock.
*/
package mcl_pkg;
  // Line levels: ON is low, OFF is high on every modem-control line
  localparam logic LINE_ON  = 1'b0;
  localparam logic LINE_OFF = 1'b1;

  // Power-save setting codes
  localparam logic [1:0] PSV_DISABLED = 2'h0;
  localparam logic [1:0] PSV_CYCLIC   = 2'h1;
  localparam logic [1:0] PSV_RTS_CTRL = 2'h2;
  localparam logic [1:0] PSV_DTR_CTRL = 2'h3;

  // Clock and time figures
  localparam int CLK_HZ        = 50_000_000;
  localparam int WAKE_MS       = 20;
  localparam int RING_ON_MS    = 1000;
  localparam int RING_OFF_MS   = 4000;
  localparam int CHAR_STOP_MAX = 2;

  // Derived cycle counts
  localparam int WAKE_CYC     = CLK_HZ / 1000 * WAKE_MS;
  localparam int RING_ON_CYC  = CLK_HZ / 1000 * RING_ON_MS;
  localparam int RING_OFF_CYC = CLK_HZ / 1000 * RING_OFF_MS;

  // Ring-cadence timer width covers the 5 s period
  localparam int RT_W = 28;
endpackage : mcl_pkg

// ---- core/mcl_ring_timer.sv ----
/*
  Ring-indicator pulse generator: retriggerable one-shot for message and
  extended events, plus a 1 s ON / 4 s OFF cadence while a call rings.
  Assumes synchronous single-cycle event pulses on the module clock.
*/
module mcl_ring_timer #(
  parameter int ON_CYC  = mcl_pkg::RING_ON_CYC,
  parameter int OFF_CYC = mcl_pkg::RING_OFF_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rstn,
  input  wire logic i_call_ring,
  input  wire logic i_call_answer,
  input  wire logic i_evt,
  output logic      o_ri_on
);
  localparam int W = mcl_pkg::RT_W;

  initial begin
    if (ON_CYC < 1 || OFF_CYC < 1 || ON_CYC + OFF_CYC >= (1 << W))
      $error("mcl_ring_timer: pulse counts out of range");
  end

  typedef struct packed {
    logic [W-1:0] ev_cnt;
    logic [W-1:0] cad_cnt;
    logic         ri_on;
  } mcl_rt_s;

  mcl_rt_s s_q;
  mcl_rt_s s_d;

  // Cadence counter runs only while ringing; event one-shot reloads on each event
  always_comb begin
    s_d = s_q;
    if (i_evt) begin
      s_d.ev_cnt = W'(ON_CYC);
    end else if (s_q.ev_cnt != '0) begin
      s_d.ev_cnt = s_q.ev_cnt - 1'b1;
    end
    if (!i_call_ring || i_call_answer) begin
      s_d.cad_cnt = '0;
    end else if (s_q.cad_cnt == W'(ON_CYC + OFF_CYC)) begin
      // Count runs 1..ON+OFF so the first ON phase is as long as the rest
      s_d.cad_cnt = W'(1);
    end else begin
      s_d.cad_cnt = s_q.cad_cnt + 1'b1;
    end
    // Answer kills only the call cadence; message pulses still run out
    s_d.ri_on = (s_d.ev_cnt != '0) ||
                (i_call_ring && !i_call_answer && s_d.cad_cnt <= W'(ON_CYC));
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_ri_on = s_q.ri_on;

  a_ring_start_on: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_evt |=> o_ri_on) else $error("ring indicator not on after event");
  a_answer_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    (i_call_answer && s_q.ev_cnt <= 1 && !i_evt) |=> !o_ri_on)
    else $error("ring indicator still on after answer");
endmodule : mcl_ring_timer

// ---- test/mcl_host_model.sv ----
/*
  Host terminal model: drives the RTS and DTR request lines of the port.
  Assumes the bench states each wish one clock ahead of the line change.
*/
module mcl_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_rts_on,
  input  wire logic i_dtr_on,
  output logic      o_rts_n,
  output logic      o_dtr_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Undriven lines rest OFF, as the pad pull-up leaves them
  initial begin
    o_rts_n = 1'b1;
    o_dtr_n = 1'b1;
  end

  // ON is low; lines move just after an edge, then hold
  always @(posedge i_clk_sys) begin
    o_rts_n <= ~i_rts_on;
    o_dtr_n <= ~i_dtr_on;
  end
endmodule : mcl_host_model

// ---- test/mcl_modem_ctrl_bench.sv ----
/*
  Self-checking bench for the modem-control lines, one task a scenario.
  Assumes short cycle counts are set on the block to keep the run brief.
*/
module mcl_modem_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WK   = 20;
  localparam int RON  = 10;
  localparam int ROFF = 40;

  logic       clk = 1'b0, rstn = 1'b0, rts_req = 1'b0, dtr_req = 1'b0;
  logic [1:0] psv = 2'h0;
  logic [4:0] cz  = 5'h00;
  logic [4:0] ev  = 5'h00;
  logic       flow = 1'b0, dsrf = 1'b1, dcdf = 1'b1, msg_en = 1'b0, ext_en = 1'b0;
  logic       ring = 1'b0;
  logic       rts_n, dtr_n, dsr_n, dcd_n, ri_n, tx_en, uart_en, wake, stay, go, feff;
  int         n_fail = 0, check_count = 0, n;

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  mcl_host_model host (.i_clk_sys(clk), .i_rts_on(rts_req), .i_dtr_on(dtr_req),
    .o_rts_n(rts_n), .o_dtr_n(dtr_n));

  // Short counts so ring cadence and wake fit in a few hundred cycles
  mcl_modem_ctrl #(.WAKE_CYC(WK), .RING_ON_CYC(RON), .RING_OFF_CYC(ROFF)) uut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_rts_n(rts_n), .i_dtr_n(dtr_n),
    .i_power_save_setting(psv), .i_hw_flow_en(flow), .i_dsr_follow_mode(dsrf),
    .i_dcd_follow_mode(dcdf), .i_msg_ring_en(msg_en),
    .i_extended_ring_notification(ext_en), .i_data_mode(cz[2]), .i_carrier(cz[0]),
    .i_voice_call(cz[1]), .i_data_call(cz[3]), .i_input_prompt(cz[4]),
    .i_call_ringing(ring), .i_call_answer(ev[2]), .i_msg_arrival(ev[0]),
    .i_ext_event(ev[1]), .i_connect_req(ev[3]), .i_tx_char_done(ev[4]),
    .o_dsr_n(dsr_n), .o_dcd_n(dcd_n), .o_ri_n(ri_n), .o_tx_enable(tx_en),
    .o_uart_enable(uart_en), .o_wake_done(wake), .o_stay_active(stay),
    .o_connect_go(go), .o_flow_eff(feff));

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt

  // Output picker so one bounded wait serves every status line
  function automatic logic pick(input int k);
    logic [8:0] v;
    v = {stay, feff, go, wake, uart_en, tx_en, ri_n, dcd_n, dsr_n};
    return v[k];
  endfunction : pick

  // Counts edges until the output shows v; a hang ends the run
  task automatic wait_sig(input int k, input logic v, output int c);
    c = 0;
    while (pick(k) !== v) begin
      @(posedge clk);
      #1;
      c++;
      if (c > 300) begin
        n_fail++;
        end_of_test();
      end
    end
  endtask : wait_sig

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : tick

  // One-cycle event: 0 message, 1 extended, 2 answer, 3 connect, 4 char done
  task automatic pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    #1;
  endtask : pulse

  task automatic t_idle;
    chk_bit(dsr_n, 1'b1);
    chk_bit(dcd_n, 1'b1);
    chk_bit(ri_n, 1'b1);
    $display("test idle done");
  endtask : t_idle

  // Each carrier-detect cause alone, then overlap, then fixed modes
  task automatic t_lines;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      cz <= 5'h01 << i;
      tick(2);
      chk_bit(dcd_n, 1'b0);
      chk_bit(dsr_n, i != 2);
      @(posedge clk);
      cz <= 5'h00;
      tick(2);
      chk_bit(dcd_n, 1'b1);
    end
    @(posedge clk);
    cz <= 5'h18;
    @(posedge clk);
    cz <= 5'h10;
    tick(2);
    chk_bit(dcd_n, 1'b0);
    @(posedge clk);
    cz <= 5'h00;
    dsrf <= 1'b0;
    dcdf <= 1'b0;
    tick(2);
    chk_bit(dsr_n, 1'b0);
    chk_bit(dcd_n, 1'b0);
    @(posedge clk);
    dsrf <= 1'b1;
    dcdf <= 1'b1;
    $display("test lines done");
  endtask : t_lines

  // Confirmation must wait for carrier detect, raised by data mode
  task automatic t_connect;
    pulse(3);
    tick(3);
    chk_bit(go, 1'b0);
    @(posedge clk);
    cz <= 5'h04;
    wait_sig(6, 1'b1, n);
    chk_bit(dcd_n, 1'b0);
    tick(1);
    chk_bit(go, 1'b0);
    @(posedge clk);
    cz <= 5'h00;
    $display("test connect done");
  endtask : t_connect

  task automatic t_flow;
    @(posedge clk);
    flow <= 1'b1;
    rts_req <= 1'b1;
    wait_sig(3, 1'b1, n);
    tick(2);
    chk_bit(feff, 1'b1);
    @(posedge clk);
    rts_req <= 1'b0;
    wait_sig(3, 1'b0, n);
    chk_bit(n <= 4, 1'b1);
    @(posedge clk);
    rts_req <= 1'b1;
    wait_sig(3, 1'b1, n);
    chk_bit(n <= 4, 1'b1);
    @(posedge clk);
    psv <= 2'h2;
    tick(2);
    chk_bit(feff, 1'b0);
    $display("test flow done");
  endtask : t_flow

  // Wake by RTS in setting 2, by DTR in setting 3
  task automatic t_wake;
    for (int s = 2; s < 4; s++) begin
      @(posedge clk);
      psv <= s[1:0];
      flow <= 1'b0;
      rts_req <= 1'b0;
      tick(4);
      chk_bit(uart_en, 1'b0);
      @(posedge clk);
      if (s == 2) rts_req <= 1'b1;
      else dtr_req <= 1'b1;
      wait_sig(4, 1'b1, n);
      chk_bit(stay, 1'b1);
      wait_sig(5, 1'b1, n);
      chk_cnt(n, WK);
      @(posedge clk);
      rts_req <= 1'b0;
      dtr_req <= 1'b0;
      wait_sig(4, 1'b0, n);
      chk_bit(stay, 1'b0);
    end
    @(posedge clk);
    psv <= 2'h0;
    tick(2);
    chk_bit(uart_en, 1'b1);
    $display("test wake done");
  endtask : t_wake

  task automatic t_ring;
    pulse(0);
    tick(1);
    chk_bit(ri_n, 1'b1);
    @(posedge clk);
    msg_en <= 1'b1;
    ext_en <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      chk_bit(ri_n, 1'b0);
      wait_sig(2, 1'b1, n);
      chk_cnt(n, RON);
    end
    // Second event two cycles on must stretch the pulse, not split it
    pulse(0);
    pulse(1);
    wait_sig(2, 1'b1, n);
    chk_cnt(n, RON);
    @(posedge clk);
    ring <= 1'b1;
    wait_sig(2, 1'b0, n);
    wait_sig(2, 1'b1, n);
    chk_cnt(n, RON);
    wait_sig(2, 1'b0, n);
    chk_cnt(n, ROFF);
    @(posedge clk);
    ev[2] <= 1'b1;
    ring <= 1'b0;
    @(posedge clk);
    ev[2] <= 1'b0;
    wait_sig(2, 1'b1, n);
    chk_bit(n < 3, 1'b1);
    $display("test ring done");
  endtask : t_ring

  // Reset for ten cycles, idle levels checked inside and after it
  initial begin
    repeat (3) @(posedge clk);
    #1;
    t_idle();
    repeat (7) @(posedge clk);
    rstn <= 1'b1;
    tick(2);
    t_idle();
    t_lines();
    t_connect();
    t_flow();
    t_wake();
    t_ring();
    end_of_test();
  end
endmodule : mcl_modem_ctrl_bench
